// file: verilog/clr_map.vh
// Operation
// - Wait-on-supply 0 with valid charging input above undervoltage forces ON, no WAIT.
// - Wait-on-supply 1 with a source present enables WAIT, converters stay off.
// - Charger-reset bit clears all charger timers and restarts charge algorithm.
// - Timer-enable selects taper comparator or taper timer onto status bit 3.
// - Charge-current field scales full, 75, 50 or 25 percent of maximum.
// - USB limit bit picks 100 mA or 500 mA; ignored without USB permit.
// - USB-permit bit 0 blocks charging from USB input.
// - Charge-enable 0 blocks charging; with both inputs valid, adapter wins.
// - First indicator on-time counts 10 ms steps, minimum 10 ms.
// - First indicator period counts 100 ms steps, minimum 100 ms.
// - Power-good control: charger, blink, off, always on.
// - Second indicator control: off, blink, off, always on.
// - Second indicator on-time counts 10 ms steps, minimum 10 ms.
// - Second indicator period counts 100 ms steps, minimum 100 ms.
// - Forced-PWM bit keeps both converters out of pulse frequency mode.
// - Undervoltage field selects 2.5, 2.75, 3.0 or 3.25 V.
// - Pin high and enable set: supply-select picks WAIT or LOW POWER.
// - Low-power-enable bit gates the sleep request pin function.
// - Discharge bit discharges main output whenever that converter is disabled.
// - Main voltage field selects 2.5 to 3.3 V; low bit from strap.
// - Charger configuration at 07h resets to 1Bh.
`ifndef CLR_MAP_VH
`define CLR_MAP_VH
`define CLR_DEV_ADDR 7'h48
`define CLR_ADDR_CHGCFG 8'h07
`define CLR_ADDR_IND1_ON 8'h08
`define CLR_ADDR_IND1_PER 8'h09
`define CLR_ADDR_IND2_ON 8'h0a
`define CLR_ADDR_IND2_PER 8'h0b
`define CLR_ADDR_MAIN 8'h0c
`define CLR_RST_CHGCFG 8'h1b
`define CLR_RST_IND 8'h00
`define CLR_RST_MAIN 8'h32
`define CLR_CFG_WAIT 7
`define CLR_CFG_CHRST 6
`define CLR_CFG_TIMER 5
`define CLR_CFG_CUR_HI 4
`define CLR_CFG_CUR_LO 3
`define CLR_CFG_USB500 2
`define CLR_CFG_USBOK 1
`define CLR_CFG_CHGEN 0
`define CLR_CTL_BIT 7
`define CLR_MAIN_FIXFREQ 7
`define CLR_MAIN_UV_HI 6
`define CLR_MAIN_UV_LO 5
`define CLR_MAIN_SUPSEL 4
`define CLR_MAIN_LPEN 3
`define CLR_MAIN_DISCH 2
`define CLR_MAIN_V_HI 1
`define CLR_MAIN_V_LO 0
`define CLR_MODE_CHG 2'b00
`define CLR_MODE_BLINK 2'b01
`define CLR_MODE_ON 2'b11
`define CLR_CLK_PERIOD_NS 8
`define CLR_ON_STEP_MS 10
`define CLR_STEP_CYCLES ((`CLR_ON_STEP_MS * 1000000) / `CLR_CLK_PERIOD_NS)
`define CLR_PER_STEPS 10
`endif

// file: verilog/clr_blinker.v
`timescale 1ns/1ps
`include "clr_map.vh"
module clr_blinker (
  clk,
  reset_n,
  ce,
  run,
  tick,
  on_field,
  per_field,
  conduct
);
  input wire clk;
  input wire reset_n;
  input wire ce;
  input wire run;
  input wire tick;
  input wire [6:0] on_field;
  input wire [6:0] per_field;
  output wire conduct;

  reg [10:0] phase_q;
  wire [10:0] on_ticks;
  wire [10:0] per_ticks;

  // Code zero still gives one step, the shortest time
  assign on_ticks = {4'h0, on_field} + 11'h001;
  assign per_ticks = ({4'h0, per_field} + 11'h001) * 11'd`CLR_PER_STEPS;
  assign conduct = run && (phase_q < on_ticks);

  always @(posedge clk) begin
    if (!reset_n) begin
      phase_q <= 11'h000;
    end else if (ce) begin
      if (!run) begin
        phase_q <= 11'h000;
      end else if (tick) begin
        if (phase_q >= per_ticks - 11'h001) begin
          phase_q <= 11'h000;
        end else begin
          phase_q <= phase_q + 11'h001;
        end
      end
    end
  end
endmodule

// file: verilog/clr_regs.v
`timescale 1ns/1ps
`include "clr_map.vh"
module clr_regs #(
  parameter STEP_CYCLES = `CLR_STEP_CYCLES
) (
  clk,
  reset_n,
  ce,
  scl_in,
  sda_in,
  sda_out,
  sda_oe,
  adapter_valid,
  usb_valid,
  supply_above_undervoltage_lockout,
  taper_comparator,
  taper_timer_state,
  charger_indicator_req,
  sleep_request_pin,
  rail_a_default_strap,
  force_on,
  wait_enable,
  charger_timer_clear,
  fast_taper_timer_en,
  charger_status_bit3,
  current_scale,
  usb_current_500,
  charge_from_adapter,
  charge_from_usb,
  power_good_indicator_out,
  second_indicator_out,
  forced_fixed_freq,
  undervoltage_lockout,
  lowpower_mode,
  wait_mode_pin,
  main_discharge,
  peripheral_rail_sel
);
  input wire clk;
  input wire reset_n;
  input wire ce;
  input wire scl_in;
  input wire sda_in;
  output reg sda_out;
  output reg sda_oe;
  input wire adapter_valid;
  input wire usb_valid;
  input wire supply_above_undervoltage_lockout;
  input wire taper_comparator;
  input wire taper_timer_state;
  input wire charger_indicator_req;
  input wire sleep_request_pin;
  input wire rail_a_default_strap;
  output reg force_on;
  output reg wait_enable;
  output reg charger_timer_clear;
  output reg fast_taper_timer_en;
  output reg charger_status_bit3;
  output reg [1:0] current_scale;
  output reg usb_current_500;
  output reg charge_from_adapter;
  output reg charge_from_usb;
  output reg power_good_indicator_out;
  output reg second_indicator_out;
  output reg forced_fixed_freq;
  output reg [1:0] undervoltage_lockout;
  output reg lowpower_mode;
  output reg wait_mode_pin;
  output reg main_discharge;
  output reg [1:0] peripheral_rail_sel;

  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_PTR = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_ACK = 3'd4;
  localparam ST_RDATA = 3'd5;
  localparam ST_RACK = 3'd6;

  reg [7:0] chgcfg_q;
  reg [7:0] ind_on_q [0:1];
  reg [7:0] ind_per_q [0:1];
  reg [7:0] main_q;
  reg strap_done_q;
  reg scl_q;
  reg sda_q;
  reg [2:0] state_q;
  reg [2:0] after_ack_q;
  reg [3:0] cnt_q;
  reg [7:0] shreg_q;
  reg [7:0] ptr_q;
  reg nack_q;
  reg [22:0] pre_q;
  reg tick_q;
  reg [7:0] rdata;
  reg [1:0] run;
  wire [1:0] conduct;
  wire start_c;
  wire stop_c;
  wire scl_rise;
  wire scl_fall;
  wire wr_en;

  // Bus lines are taken as synchronous; previous sample gives the edges
  assign start_c = scl_in && scl_q && sda_q && !sda_in;
  assign stop_c = scl_in && scl_q && !sda_q && sda_in;
  assign scl_rise = scl_in && !scl_q;
  assign scl_fall = !scl_in && scl_q;
  assign wr_en = (state_q == ST_WDATA) && scl_fall && (cnt_q == 4'd8);

  always @* begin
    case (ptr_q)
      `CLR_ADDR_CHGCFG: rdata = chgcfg_q;
      `CLR_ADDR_IND1_ON: rdata = ind_on_q[0];
      `CLR_ADDR_IND1_PER: rdata = ind_per_q[0];
      `CLR_ADDR_IND2_ON: rdata = ind_on_q[1];
      `CLR_ADDR_IND2_PER: rdata = ind_per_q[1];
      `CLR_ADDR_MAIN: rdata = main_q;
      default: rdata = 8'h00;
    endcase
  end

  // Serial slave: address, pointer, then data with pointer increment
  always @(posedge clk) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state_q <= ST_IDLE;
      after_ack_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shreg_q <= 8'h00;
      ptr_q <= 8'h00;
      nack_q <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else if (ce) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      sda_out <= 1'b0;
      if (start_c) begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state_q <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            if (scl_rise && cnt_q < 4'd8) begin
              shreg_q <= {shreg_q[6:0], sda_in};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'd8) begin
              cnt_q <= 4'h0;
              if (state_q == ST_ADDR) begin
                if (shreg_q[7:1] == `CLR_DEV_ADDR) begin
                  sda_oe <= 1'b1;
                  state_q <= ST_ACK;
                  after_ack_q <= shreg_q[0] ? ST_RDATA : ST_PTR;
                end else begin
                  state_q <= ST_IDLE;
                end
              end else begin
                sda_oe <= 1'b1;
                state_q <= ST_ACK;
                after_ack_q <= ST_WDATA;
                if (state_q == ST_PTR) begin
                  ptr_q <= shreg_q;
                end else begin
                  ptr_q <= ptr_q + 8'h01;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              state_q <= after_ack_q;
              if (after_ack_q == ST_RDATA) begin
                shreg_q <= rdata;
                sda_oe <= ~rdata[7];
              end else begin
                sda_oe <= 1'b0;
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (cnt_q == 4'd7) begin
                sda_oe <= 1'b0;
                state_q <= ST_RACK;
                ptr_q <= ptr_q + 8'h01;
              end else begin
                cnt_q <= cnt_q + 4'h1;
                shreg_q <= {shreg_q[6:0], 1'b0};
                sda_oe <= ~shreg_q[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_in;
            end else if (scl_fall) begin
              cnt_q <= 4'h0;
              if (nack_q) begin
                state_q <= ST_IDLE;
              end else begin
                state_q <= ST_RDATA;
                shreg_q <= rdata;
                sda_oe <= ~rdata[7];
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Register storage; unmapped writes are dropped
  always @(posedge clk) begin
    if (!reset_n) begin
      chgcfg_q <= `CLR_RST_CHGCFG;
      ind_on_q[0] <= `CLR_RST_IND;
      ind_per_q[0] <= `CLR_RST_IND;
      ind_on_q[1] <= `CLR_RST_IND;
      ind_per_q[1] <= `CLR_RST_IND;
      main_q <= `CLR_RST_MAIN;
      strap_done_q <= 1'b0;
    end else if (ce) begin
      // Strap caught once after release, so a later host write wins
      if (!strap_done_q) begin
        main_q[`CLR_MAIN_V_LO] <= rail_a_default_strap;
        strap_done_q <= 1'b1;
      end
      if (wr_en) begin
        case (ptr_q)
          `CLR_ADDR_CHGCFG: chgcfg_q <= shreg_q;
          `CLR_ADDR_IND1_ON: ind_on_q[0] <= shreg_q;
          `CLR_ADDR_IND1_PER: ind_per_q[0] <= shreg_q;
          `CLR_ADDR_IND2_ON: ind_on_q[1] <= shreg_q;
          `CLR_ADDR_IND2_PER: ind_per_q[1] <= shreg_q;
          `CLR_ADDR_MAIN: main_q <= shreg_q;
          default: chgcfg_q <= chgcfg_q;
        endcase
      end
    end
  end

  // Shared 10 ms step; blinker periods count ten of these
  always @(posedge clk) begin
    if (!reset_n) begin
      pre_q <= 23'h000000;
      tick_q <= 1'b0;
    end else if (ce) begin
      if (pre_q >= STEP_CYCLES - 1) begin
        pre_q <= 23'h000000;
        tick_q <= 1'b1;
      end else begin
        pre_q <= pre_q + 23'h000001;
        tick_q <= 1'b0;
      end
    end
  end

  always @* begin
    run[0] = {ind_on_q[0][`CLR_CTL_BIT], ind_per_q[0][`CLR_CTL_BIT]} == `CLR_MODE_BLINK;
    run[1] = {ind_on_q[1][`CLR_CTL_BIT], ind_per_q[1][`CLR_CTL_BIT]} == `CLR_MODE_BLINK;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ind
      clr_blinker u_blink (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .run(run[gi]),
        .tick(tick_q),
        .on_field(ind_on_q[gi][6:0]),
        .per_field(ind_per_q[gi][6:0]),
        .conduct(conduct[gi])
      );
    end
  endgenerate

  // Registered decode of every control output
  always @(posedge clk) begin
    if (!reset_n) begin
      force_on <= 1'b0;
      wait_enable <= 1'b0;
      charger_timer_clear <= 1'b0;
      fast_taper_timer_en <= 1'b0;
      charger_status_bit3 <= 1'b0;
      current_scale <= 2'b00;
      usb_current_500 <= 1'b0;
      charge_from_adapter <= 1'b0;
      charge_from_usb <= 1'b0;
      power_good_indicator_out <= 1'b0;
      second_indicator_out <= 1'b0;
      forced_fixed_freq <= 1'b0;
      undervoltage_lockout <= 2'b00;
      lowpower_mode <= 1'b0;
      wait_mode_pin <= 1'b0;
      main_discharge <= 1'b0;
      peripheral_rail_sel <= 2'b00;
    end else if (ce) begin
      force_on <= !chgcfg_q[`CLR_CFG_WAIT] && (adapter_valid || usb_valid) && supply_above_undervoltage_lockout;
      wait_enable <= chgcfg_q[`CLR_CFG_WAIT] && (adapter_valid || usb_valid);
      // Level, not pulse: timers held clear until host writes 0 again
      charger_timer_clear <= chgcfg_q[`CLR_CFG_CHRST];
      fast_taper_timer_en <= chgcfg_q[`CLR_CFG_TIMER];
      charger_status_bit3 <= chgcfg_q[`CLR_CFG_TIMER] ? taper_timer_state : taper_comparator;
      current_scale <= {chgcfg_q[`CLR_CFG_CUR_HI], chgcfg_q[`CLR_CFG_CUR_LO]};
      usb_current_500 <= chgcfg_q[`CLR_CFG_USB500] && chgcfg_q[`CLR_CFG_USBOK];
      charge_from_adapter <= chgcfg_q[`CLR_CFG_CHGEN] && adapter_valid;
      charge_from_usb <= chgcfg_q[`CLR_CFG_CHGEN] && chgcfg_q[`CLR_CFG_USBOK] && usb_valid && !adapter_valid;
      case ({ind_on_q[0][`CLR_CTL_BIT], ind_per_q[0][`CLR_CTL_BIT]})
        `CLR_MODE_CHG: power_good_indicator_out <= charger_indicator_req;
        `CLR_MODE_BLINK: power_good_indicator_out <= conduct[0];
        `CLR_MODE_ON: power_good_indicator_out <= 1'b1;
        default: power_good_indicator_out <= 1'b0;
      endcase
      case ({ind_on_q[1][`CLR_CTL_BIT], ind_per_q[1][`CLR_CTL_BIT]})
        `CLR_MODE_BLINK: second_indicator_out <= conduct[1];
        `CLR_MODE_ON: second_indicator_out <= 1'b1;
        default: second_indicator_out <= 1'b0;
      endcase
      forced_fixed_freq <= main_q[`CLR_MAIN_FIXFREQ];
      undervoltage_lockout <= {main_q[`CLR_MAIN_UV_HI], main_q[`CLR_MAIN_UV_LO]};
      lowpower_mode <= sleep_request_pin && main_q[`CLR_MAIN_LPEN] && main_q[`CLR_MAIN_SUPSEL];
      wait_mode_pin <= sleep_request_pin && main_q[`CLR_MAIN_LPEN] && !main_q[`CLR_MAIN_SUPSEL];
      // Main converter is off in either WAIT source
      main_discharge <= main_q[`CLR_MAIN_DISCH] && (wait_enable || wait_mode_pin);
      peripheral_rail_sel <= {main_q[`CLR_MAIN_V_HI], main_q[`CLR_MAIN_V_LO]};
    end
  end
endmodule

// file: tb/clr_regs_chk.sv
`timescale 1ns/1ps
module clr_regs_chk (
  input wire clk,
  input wire reset_n,
  input wire ce,
  input wire adapter_valid,
  input wire usb_valid,
  input wire supply_above_undervoltage_lockout,
  input wire taper_comparator,
  input wire taper_timer_state,
  input wire sleep_request_pin,
  input wire force_on,
  input wire wait_enable,
  input wire fast_taper_timer_en,
  input wire charger_status_bit3,
  input wire charge_from_adapter,
  input wire charge_from_usb,
  input wire lowpower_mode,
  input wire wait_mode_pin,
  input wire main_discharge
);
  // Previous edge was an enabled one, so outputs reflect it
  reg run_q;
  always @(posedge clk) run_q <= reset_n && ce;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  on_wait_excl_a: assert property (!(force_on && wait_enable))
    else $error("force on and wait both high");
  force_cause_a: assert property (run_q && force_on |-> $past(supply_above_undervoltage_lockout && (adapter_valid || usb_valid)))
    else $error("force on without valid source");
  wait_cause_a: assert property (run_q && wait_enable |-> $past(adapter_valid || usb_valid))
    else $error("wait without source");
  status_sel_a: assert property (run_q |->
    charger_status_bit3 == (fast_taper_timer_en ? $past(taper_timer_state) : $past(taper_comparator)))
    else $error("status bit 3 wrong source");
  src_excl_a: assert property (!(charge_from_adapter && charge_from_usb))
    else $error("both inputs charging");
  usb_path_a: assert property (run_q && charge_from_usb |-> $past(usb_valid && !adapter_valid))
    else $error("usb charging without cause");
  adapter_path_a: assert property (run_q && charge_from_adapter |-> $past(adapter_valid))
    else $error("adapter charging without cause");
  lp_gate_a: assert property (run_q && (lowpower_mode || wait_mode_pin) |->
    $past(sleep_request_pin) && !(lowpower_mode && wait_mode_pin))
    else $error("low power mode without pin");
  discharge_a: assert property (run_q && main_discharge |-> $past(wait_enable || wait_mode_pin))
    else $error("discharge while converter on");
  cover property (lowpower_mode);
  cover property (main_discharge);
  cover property (charge_from_usb);
  cover property (wait_enable);
endmodule
bind clr_regs clr_regs_chk u_clr_regs_chk (.clk, .reset_n, .ce, .adapter_valid, .usb_valid, .supply_above_undervoltage_lockout,
  .taper_comparator, .taper_timer_state, .sleep_request_pin, .force_on, .wait_enable, .fast_taper_timer_en,
  .charger_status_bit3, .charge_from_adapter, .charge_from_usb, .lowpower_mode, .wait_mode_pin, .main_discharge);

// file: tb/clr_host.sv
`timescale 1ns/1ps
`include "clr_map.vh"
module clr_host (
  input wire clk,
  input wire sda_dev_oe,
  output logic scl,
  output logic sda
);
  logic drv_low = 0;
  initial scl = 1;
  // Pull-up: line is high unless someone pulls it
  assign sda = !(drv_low || sda_dev_oe);
  task automatic hc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bitx(input logic b, output logic r);
    drv_low = !b;
    hc(3);
    scl = 1;
    hc(3);
    r = sda;
    hc(3);
    scl = 0;
    hc(1);
  endtask
  task automatic start;
    drv_low = 0;
    hc(2);
    scl = 1;
    hc(3);
    drv_low = 1;
    hc(3);
    scl = 0;
    hc(1);
  endtask
  task automatic stop;
    drv_low = 1;
    hc(2);
    scl = 1;
    hc(3);
    drv_low = 0;
    hc(3);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    start();
    wbyte({dev, 1'b0}, k1);
    wbyte(a, k2);
    wbyte(d, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // Reads n bytes (1 or 2); master ACKs all but the last
  task automatic rdn(input logic [7:0] a, input int n, output logic [15:0] d);
    logic k, r;
    d = 16'h0000;
    start();
    wbyte({`CLR_DEV_ADDR, 1'b0}, k);
    wbyte(a, k);
    start();
    wbyte({`CLR_DEV_ADDR, 1'b1}, k);
    for (int i = 8 * n - 1; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
      // Master NACK ends the read
      if (i % 8 == 0) bitx(i == 0, r);
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [15:0] w;
    rdn(a, 1, w);
    d = w[7:0];
  endtask
endmodule

// file: tb/clr_regs_bench.sv
`timescale 1ns/1ps
`include "clr_map.vh"
module clr_regs_bench;
  logic clk = 0, reset_n = 0, ce = 1, adapter_valid = 0, usb_valid = 0, supply_above_undervoltage_lockout = 0;
  logic taper_comparator = 0, taper_timer_state = 0, charger_indicator_req = 0, sleep_request_pin = 0;
  logic rail_a_default_strap = 1;
  logic scl_in, sda_in, sda_out, sda_oe, force_on, wait_enable, charger_timer_clear, fast_taper_timer_en;
  logic charger_status_bit3, usb_current_500, charge_from_adapter, charge_from_usb, power_good_indicator_out;
  logic second_indicator_out, forced_fixed_freq, lowpower_mode, wait_mode_pin, main_discharge;
  logic [1:0] current_scale, undervoltage_lockout, peripheral_rail_sel;
  int n_fail = 0, samples_checked = 0;
  // Short step keeps blink periods at tens of cycles
  clr_regs #(.STEP_CYCLES(4)) u_clr_regs (.clk, .reset_n, .ce, .scl_in, .sda_in, .sda_out, .sda_oe,
    .adapter_valid, .usb_valid, .supply_above_undervoltage_lockout, .taper_comparator, .taper_timer_state, .charger_indicator_req,
    .sleep_request_pin, .rail_a_default_strap, .force_on, .wait_enable, .charger_timer_clear, .fast_taper_timer_en,
    .charger_status_bit3, .current_scale, .usb_current_500, .charge_from_adapter, .charge_from_usb,
    .power_good_indicator_out, .second_indicator_out, .forced_fixed_freq, .undervoltage_lockout, .lowpower_mode,
    .wait_mode_pin, .main_discharge, .peripheral_rail_sel);
  clr_host u_clr_host (.clk(clk), .sda_dev_oe(sda_oe), .scl(scl_in), .sda(sda_in));
  always #4 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    logic [7:0] d;
    logic [15:0] w;
    logic ok;
    u_clr_host.rd(`CLR_ADDR_CHGCFG, d);
    chk(16'(d), 16'h001b);
    chk(16'({sda_out, sda_oe}), 16'h0000);
    // Burst read walks the pointer from 07h into 08h
    u_clr_host.rdn(`CLR_ADDR_CHGCFG, 2, w);
    chk(w, 16'h1b00);
    u_clr_host.rd(`CLR_ADDR_MAIN, d);
    chk(16'(d), 16'h0033);
    for (int a = 8; a < 12; a++) begin
      u_clr_host.rd(8'(a), d);
      chk(16'(d), 16'h0000);
    end
    // Foreign address must be ignored entirely
    u_clr_host.wr(7'h49, `CLR_ADDR_CHGCFG, 8'h00, ok);
    chk(16'(ok), 16'h0000);
    u_clr_host.rd(`CLR_ADDR_CHGCFG, d);
    chk(16'(d), 16'h001b);
  endtask
  task automatic t_cfg;
    logic [7:0] tbl [6] = '{8'hff, 8'h87, 8'h25, 8'h0e, 8'h51, 8'h1b};
    logic [7:0] c;
    logic ok;
    for (int i = 0; i < 6; i++) begin
      c = tbl[i];
      u_clr_host.wr(`CLR_DEV_ADDR, `CLR_ADDR_CHGCFG, c, ok);
      for (int j = 0; j < 8; j++) begin
        {adapter_valid, usb_valid, supply_above_undervoltage_lockout} = 3'(j);
        taper_comparator = j[0];
        taper_timer_state = !j[0];
        settle(2);
        chk(16'({force_on, wait_enable, charger_timer_clear, fast_taper_timer_en, charger_status_bit3,
          current_scale, usb_current_500, charge_from_adapter, charge_from_usb}),
          16'({!c[7] & (adapter_valid | usb_valid) & supply_above_undervoltage_lockout, c[7] & (adapter_valid | usb_valid),
          c[6], c[5], c[5] ? taper_timer_state : taper_comparator, c[4:3], c[2] & c[1],
          c[0] & adapter_valid, c[0] & c[1] & usb_valid & !adapter_valid}));
      end
    end
    // Frozen while disabled
    ce = 0;
    adapter_valid = 0;
    settle(2);
    chk(16'(charge_from_adapter), 16'h0001);
    ce = 1;
  endtask
  task automatic t_main;
    logic [7:0] tbl [5] = '{8'hff, 8'h4d, 8'h26, 8'h98, 8'h32};
    logic [7:0] m, d;
    logic ok;
    for (int i = 0; i < 5; i++) begin
      m = tbl[i];
      u_clr_host.wr(`CLR_DEV_ADDR, `CLR_ADDR_MAIN, m, ok);
      u_clr_host.rd(`CLR_ADDR_MAIN, d);
      chk(16'(d), 16'(m));
      for (int s = 0; s < 2; s++) begin
        sleep_request_pin = s[0];
        settle(3);
        chk(16'({forced_fixed_freq, undervoltage_lockout, lowpower_mode, wait_mode_pin, main_discharge,
          peripheral_rail_sel}), 16'({m[7], m[6:5], s[0] & m[4] & m[3], s[0] & !m[4] & m[3],
          s[0] & !m[4] & m[3] & m[2], m[1:0]}));
      end
    end
    sleep_request_pin = 0;
  endtask
  // Counts conducting cycles over whole periods, so phase does not matter
  task automatic t_led(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, input logic sel,
    input logic [15:0] exp);
    logic ok;
    logic [15:0] n;
    u_clr_host.wr(`CLR_DEV_ADDR, a, d0, ok);
    u_clr_host.wr(`CLR_DEV_ADDR, a + 8'h01, d1, ok);
    settle(4);
    n = 16'h0000;
    for (int i = 0; i < 160; i++) begin
      settle(1);
      n += sel ? second_indicator_out : power_good_indicator_out;
    end
    chk(n, exp);
  endtask
  initial begin
    settle(6);
    reset_n = 1;
    settle(2);
    t_reset();
    t_cfg();
    t_main();
    t_led(8'h08, 8'h01, 8'h80, 0, 16'd32);
    t_led(8'h08, 8'h80, 8'h80, 0, 16'd160);
    t_led(8'h08, 8'h80, 8'h00, 0, 16'd0);
    charger_indicator_req = 1;
    t_led(8'h08, 8'h00, 8'h00, 0, 16'd160);
    charger_indicator_req = 0;
    t_led(8'h0a, 8'h03, 8'h81, 1, 16'd32);
    t_led(8'h0a, 8'h03, 8'h01, 1, 16'd0);
    t_led(8'h0a, 8'h83, 8'h01, 1, 16'd0);
    t_led(8'h0a, 8'h83, 8'h81, 1, 16'd160);
    close_out();
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    close_out();
  end
endmodule
